// *** bench/rictm_timer_chk.sv ***
// Timing checks on the instruction cycle timer ports.
`timescale 1ns/10ps
module rictm_chk (
  input wire        sys_clk,
  input wire        nrst,
  input wire        start,
  input wire [15:0] instr_word,
  input wire        dest_long,
  input wire [6:0]  iter_count,
  input wire        busy,
  input wire        ext_word_fetch,
  input wire        done,
  input wire [6:0]  cycle_total
);
  wire       tk = start && !busy;
  wire       im = instr_word[4:0] == 5'h1f;
  wire [4:0] op = instr_word[14:10];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_div_short: assert property (tk && op == 5'h1e && !dest_long && !im |-> ##36 done)
    else $error("divide short length");
  a_div_long: assert property (tk && op == 5'h1e && dest_long && im |-> ##69 done)
    else $error("divide long length");
  a_mul_short: assert property (tk && op == 5'h1b && !dest_long && !im && iter_count == 7'h10
    |-> ##19 done)
    else $error("multiply short length");
  a_mul_long: assert property (tk && op == 5'h1b && dest_long && im && iter_count == 7'h40
    |-> ##68 done)
    else $error("multiply long length");
  a_shift_imm: assert property (tk && op == 5'h1a && im && iter_count == 7'h02 |-> ##6 done)
    else $error("shift immediate length");
  a_shift_lit: assert property (tk && op == 5'h19 && !im && iter_count == 7'h0f |-> ##18 done)
    else $error("shift literal length");
  a_move_two: assert property (tk && op == 5'h00 && !im |-> ##2 done && cycle_total == 7'h02)
    else $error("move length");
  a_fetch_second: assert property (tk && im |=> ext_word_fetch)
    else $error("second word not fetched");
endmodule
bind rictm_timer rictm_chk chk (.sys_clk, .nrst, .start, .instr_word, .dest_long, .iter_count,
  .busy, .ext_word_fetch, .done, .cycle_total);

// *** bench/test_risc_instruction_cycle_timer.sv ***
// Self-checking bench for the instruction cycle timer.
`timescale 1ns/10ps
module test_risc_instruction_cycle_timer;
  reg        sys_clk = 0, nrst = 0, start = 0, imem_access = 0, absolute_addr = 0;
  reg        dest_long = 0, wait_state = 0;
  reg [15:0] instr_word = 0, w;
  reg [6:0]  iter_count = 0, k;
  reg [31:0] r = 32'h0000_edcf;
  wire       busy, ext_word_fetch, done;
  wire [6:0] cycle_total;
  int        n_mismatch = 0, samples_checked = 0, n;
  rictm_timer uut (.sys_clk, .nrst, .start, .instr_word, .imem_access, .absolute_addr,
    .dest_long, .iter_count, .wait_state, .busy, .ext_word_fetch, .done, .cycle_total);
  always #20 sys_clk = ~sys_clk;
  task conclude;
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input [14:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  // Zero-wait length; the run task adds the wait states that it inserts on transfers.
  function [6:0] cyc(input [15:0] v, input m, a, d, input [6:0] c);
    reg i;
    i = v[4:0] == 5'h1f;
    case (v[14:10])
      5'h1e: cyc = (d ? 7'h44 : 7'h24) + i;
      5'h18, 5'h19, 5'h1a, 5'h1b: cyc = 7'h03 + c + i;
      5'h01, 5'h02: cyc = m ? 7'h04 : 7'h03 + (a | i);
      5'h05, 5'h06: cyc = 7'h03 + (a | i);
      5'h03: cyc = 7'h04;
      default: cyc = i ? 7'h04 : 7'h02;
    endcase
  endfunction
  // Data-memory and port transfers are the ones that wait and take an address word.
  function xfer(input [15:0] v, input m);
    xfer = v[14:10] == 5'h05 || v[14:10] == 5'h06 ||
           !m && (v[14:10] == 5'h01 || v[14:10] == 5'h02);
  endfunction
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task run(input [15:0] v, input m, a, d, input [6:0] c, input [1:0] ws);
    reg       x, b, f;
    reg [6:0] e;
    {instr_word, imem_access, absolute_addr, dest_long, iter_count} = {v, m, a, d, c};
    start = 1;
    wait_state = ws != 0;
    @(posedge sys_clk);
    #1 start = 0;
    x = ext_word_fetch;
    b = busy;
    n = 1;
    while (done !== 1'b1 && n < 90) begin
      @(posedge sys_clk);
      #1 n++;
      wait_state = n <= ws;
    end
    e = cyc(v, m, a, d, c) + (xfer(v, m) ? ws : 2'd0);
    f = v[4:0] == 5'h1f || a && xfer(v, m);
    check({x, n[6:0], cycle_total}, {f, e, e});
    check({b, busy}, 2'b10);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 check({busy, done, ext_word_fetch, cycle_total}, 15'h0000);
    nrst = 1;
    run(16'h7800, 0, 0, 0, 7'h10, 0);
    run(16'h781f, 0, 0, 1, 7'h10, 0);
    run(16'h6c00, 0, 0, 0, 7'h10, 0);
    run(16'h6c1f, 0, 0, 1, 7'h40, 0);
    run(16'h681f, 0, 0, 0, 7'h02, 0);
    run(16'h6000, 0, 0, 0, 7'h1f, 0);
    run(16'h6401, 0, 0, 0, 7'h0f, 0);
    run(16'h0001, 0, 0, 0, 7'h00, 0);
    run(16'h0400, 0, 0, 0, 7'h00, 3);
    run(16'h1800, 0, 1, 0, 7'h00, 1);
    repeat (40) begin
      r = lfsr(r);
      w = r[15:0];
      if (w[13:10] == 4'h7) w[13] = 1'b1;
      k = w[14:10] == 5'h1b ? {1'b0, r[18], ~r[18], r[23:20]} : {4'h0, r[22:20]} + 7'h02;
      run(w, r[16], r[17], r[18], k, r[25:24]);
    end
    conclude;
  end
  initial begin
    #400_000;
    n_mismatch++;
    conclude;
  end
endmodule

// *** design/rictm_clamp.v ***
// Range clamp for variable iteration counts.
`timescale 1ns/10ps
module rictm_clamp (
  input  wire [6:0] value,
  input  wire [6:0] lo,
  input  wire [6:0] hi,
  output wire [6:0] clamped
);
  assign clamped = (value < lo) ? lo : ((value > hi) ? hi : value);
endmodule

// *** design/rictm_timer.v ***
// Instruction cycle timer: counts the clock cycles each native instruction occupies.
`timescale 1ns/10ps
`include "rictm_regs.vh"
module rictm_timer (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        start,
  input  wire [15:0] instr_word,
  input  wire        imem_access,
  input  wire        absolute_addr,
  input  wire        dest_long,
  input  wire [6:0]  iter_count,
  input  wire        wait_state,
  output reg         busy,
  output reg         ext_word_fetch,
  output reg         done,
  output reg  [6:0]  cycle_total
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN  = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg [1:0] state;
  reg [6:0] remain;
  reg [6:0] spent;
  reg [6:0] base;
  reg       is_mem;
  reg       two_word;
  reg [6:0] next_remain;
  reg [6:0] next_spent;
  reg       finish;

  ////////////////////////////////////////////////////////////////////////
  // Cycle arithmetic shared by the operation classes.
  function is_shift_op(input [4:0] op);
    begin
      is_shift_op = (op == `RICTM_OP_LSHIFT) ||
                    (op == `RICTM_OP_ASHIFT) ||
                    (op == `RICTM_OP_CSHIFT);
    end
  endfunction

  // Picks the register or literal figure, or the long-immediate figure.
  function [6:0] form_cycles(input long_form, input [6:0] short_c, input [6:0] long_c);
    begin
      if (long_form) begin
        form_cycles = long_c;
      end else begin
        form_cycles = short_c;
      end
    end
  endfunction

  // Zero-wait length of a data or port transfer; the sequencer adds the waits.
  function [6:0] mem_cycles(input long_src, input abs_addr);
    begin
      mem_cycles = form_cycles(long_src || abs_addr, `RICTM_CYC_MEM, `RICTM_CYC_MEM_L);
    end
  endfunction

  // Divide length: the wide destination takes the long iteration path.
  function [6:0] div_cycles(input long_src, input wide_dest);
    begin
      if (wide_dest) begin
        div_cycles = form_cycles(long_src, `RICTM_CYC_DIV_LONG, `RICTM_CYC_DIV_LG_L);
      end else begin
        div_cycles = form_cycles(long_src, `RICTM_CYC_DIV_S, `RICTM_CYC_DIV_S_L);
      end
    end
  endfunction

  // Legal band of the variable count. Register and literal counts share one
  // band, since a literal count above 15 is never issued by the caller.
  function [6:0] var_lo(input shift_op, input wide_dest);
    begin
      if (shift_op) begin
        var_lo = `RICTM_SHIFT_MIN;
      end else if (wide_dest) begin
        var_lo = `RICTM_K32_MIN;
      end else begin
        var_lo = `RICTM_K16_MIN;
      end
    end
  endfunction

  function [6:0] var_hi(input shift_op, input wide_dest);
    begin
      if (shift_op) begin
        var_hi = `RICTM_NREG_MAX;
      end else if (wide_dest) begin
        var_hi = `RICTM_K32_MAX;
      end else begin
        var_hi = `RICTM_K16_MAX;
      end
    end
  endfunction

  wire [4:0] opcode = instr_word[`RICTM_OP_MSB:`RICTM_OP_LSB];
  wire       src_imm = (instr_word[`RICTM_SRC_MSB:`RICTM_SRC_LSB] == `RICTM_SRC_IMM);
  wire       is_shift = is_shift_op(opcode);
  wire [6:0] lo_sel   = var_lo(is_shift, dest_long);
  wire [6:0] hi_sel   = var_hi(is_shift, dest_long);
  wire [6:0] var_count;

  ////////////////////////////////////////////////////////////////////////
  // Shift counts and multiply iterations are held inside their legal band.
  rictm_clamp u_clamp (
    .value   (iter_count),
    .lo      (lo_sel),
    .hi      (hi_sel),
    .clamped (var_count)
  );

  // Absolute addressing and a long immediate both bring a second word, so
  // either one lengthens a data or port transfer by the extra fetch cycle.
  always @* begin
    is_mem   = 1'b0;
    two_word = src_imm;
    base     = form_cycles(src_imm, `RICTM_CYC_SIMPLE, `RICTM_CYC_SIMPLE_L);
    case (opcode)
      `RICTM_OP_LOAD, `RICTM_OP_STORE: begin
        if (imem_access) begin
          base = `RICTM_CYC_IMEM;
        end else begin
          is_mem   = 1'b1;
          two_word = src_imm || absolute_addr;
          base     = mem_cycles(src_imm, absolute_addr);
        end
      end
      `RICTM_OP_IN, `RICTM_OP_OUT: begin
        is_mem   = 1'b1;
        two_word = src_imm || absolute_addr;
        base     = mem_cycles(src_imm, absolute_addr);
      end
      `RICTM_OP_CALL: begin
        base = `RICTM_CYC_CALL;
      end
      `RICTM_OP_LSHIFT, `RICTM_OP_ASHIFT, `RICTM_OP_CSHIFT, `RICTM_OP_MUL: begin
        base = form_cycles(src_imm, `RICTM_CYC_VAR, `RICTM_CYC_VAR_L) + var_count;
      end
      `RICTM_OP_DIV: begin
        base = div_cycles(src_imm, dest_long);
      end
      default: begin
        base = form_cycles(src_imm, `RICTM_CYC_SIMPLE, `RICTM_CYC_SIMPLE_L);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next values of the sequencer. A wait cycle holds the remaining count,
  // so each wait state a data or port transfer sees before its first ready cycle adds exactly one cycle to the total.
  always @* begin
    next_remain = remain - 7'd1;
    next_spent  = spent + 7'd1;
    finish      = 1'b0;
    case (state)
      ST_WAIT: begin
        if (wait_state) begin
          next_remain = remain;
        end else begin
          finish = (remain == 7'd1);
        end
      end
      ST_RUN: begin
        finish = (remain == 7'd1);
      end
      default: begin
        next_remain = remain;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Wait states extend the count one cycle each before the fixed cycles
  // are spent, so W never hides inside the base figure.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state          <= ST_IDLE;
      remain         <= 7'd0;
      spent          <= 7'd0;
      busy           <= 1'b0;
      ext_word_fetch <= 1'b0;
      done           <= 1'b0;
      cycle_total    <= 7'd0;
    end else begin
      done           <= 1'b0;
      ext_word_fetch <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            remain         <= base - 7'd1;
            spent          <= 7'd1;
            busy           <= 1'b1;
            ext_word_fetch <= two_word;
            state          <= is_mem ? ST_WAIT : ST_RUN;
          end
        end
        ST_WAIT: begin
          spent  <= next_spent;
          remain <= next_remain;
          if (!wait_state) begin
            state <= ST_RUN;
          end
          if (finish) begin
            busy        <= 1'b0;
            done        <= 1'b1;
            cycle_total <= next_spent;
            state       <= ST_IDLE;
          end
        end
        ST_RUN: begin
          spent  <= next_spent;
          remain <= next_remain;
          if (finish) begin
            busy        <= 1'b0;
            done        <= 1'b1;
            cycle_total <= next_spent;
            state       <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** shared/rictm_regs.vh ***
// Opcode, operand-form and cycle-count constants for the instruction cycle timer.
`ifndef RICTM_REGS_VH
`define RICTM_REGS_VH
`define RICTM_OP_MSB        14
`define RICTM_OP_LSB        10
`define RICTM_SRC_MSB       4
`define RICTM_SRC_LSB       0
`define RICTM_SRC_IMM       5'h1f
`define RICTM_OP_MOV        5'h00
`define RICTM_OP_LOAD       5'h01
`define RICTM_OP_STORE      5'h02
`define RICTM_OP_CALL       5'h03
`define RICTM_OP_IN         5'h05
`define RICTM_OP_OUT        5'h06
`define RICTM_OP_LSHIFT     5'h18
`define RICTM_OP_ASHIFT     5'h19
`define RICTM_OP_CSHIFT     5'h1a
`define RICTM_OP_MUL        5'h1b
`define RICTM_OP_DIV        5'h1e
`define RICTM_OP_JUMP       5'h1f
`define RICTM_CYC_SIMPLE    7'd2
`define RICTM_CYC_SIMPLE_L  7'd4
`define RICTM_CYC_MEM       7'd3
`define RICTM_CYC_MEM_L     7'd4
`define RICTM_CYC_CALL      7'd4
`define RICTM_CYC_IMEM      7'd4
`define RICTM_CYC_VAR       7'd3
`define RICTM_CYC_VAR_L     7'd4
`define RICTM_CYC_DIV_S     7'd36
`define RICTM_CYC_DIV_LONG  7'd68
`define RICTM_CYC_DIV_S_L   7'd37
`define RICTM_CYC_DIV_LG_L  7'd69
`define RICTM_K16_MIN       7'd16
`define RICTM_K16_MAX       7'd32
`define RICTM_K32_MIN       7'd32
`define RICTM_K32_MAX       7'd64
`define RICTM_NREG_MAX      7'd31
`define RICTM_MLIT_MAX      7'd15
`define RICTM_SHIFT_MIN     7'd2
`endif
